//--- nv_access.sv
`timescale 1ns/1ns
module nv_access
  import nv_access_pkg::*;
#(
  parameter int WRITE_LEN = WRITE_CYCLES
) (
  input wire logic I_CLK, // system clock
  input wire logic I_NRST, // synchronous reset, active low
  input wire logic [7:0] I_ADDR, // register address, direct
  input wire logic I_WR, // register write strobe
  input wire logic [7:0] I_WDATA, // register write data
  input wire logic I_DONE_CLR, // software clears done flag
  input wire logic I_MF_SERVICE, // service pulse clears request
  output logic [7:0] O_RDATA, // register read data, one cycle late
  output logic O_DONE_FLAG, // write completion flag
  output logic O_MF_REQ, // multi-function request flag
  output logic O_BUSY // cycle in progress
);
  // --------------------------------------------------------------
  // parameter check
  // --------------------------------------------------------------
  if (WRITE_LEN < 1 || WRITE_LEN > 65535) begin : g_bad_len
    $error("write length out of range");
  end

  // --------------------------------------------------------------
  // storage
  // --------------------------------------------------------------
  logic [NV_AW-1:0] nv_location;
  logic [7:0] nv_byte;
  logic [7:0] ptr_one;
  logic bank_sel;
  logic prog_en, prog_go, read_en, read_go;
  logic [15:0] wcount;
  nv_state_t state, next_state;
  logic [NV_AW-1:0] wr_loc;
  logic [7:0] wr_byte;

  nv_mem_if #(.AW(NV_AW)) mem_port ();

  nv_array #(.DEPTH(NV_DEPTH)) u_array (
    .clk(I_CLK),
    .port(mem_port)
  );

  // --------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------
  // indirect port lands on pointer address in the selected bank
  function automatic logic hit(input logic [7:0] target,
                               input logic target_bank,
                               input logic [7:0] addr);
    logic ind;
    ind = (addr == IND_PORT_ADDR);
    if (ind) begin
      hit = (ptr_one == target) && (bank_sel == target_bank)
            && (target != IND_PORT_ADDR);
    end else begin
      hit = (addr == target) && !target_bank;
    end
  endfunction : hit

  wire loc_hit = hit(NV_LOCATION_ADDR, 1'b0, I_ADDR);
  wire byte_hit = hit(NV_BYTE_ADDR, 1'b0, I_ADDR);
  wire ctl_hit = hit(NV_CONTROL_ADDR, 1'b1, I_ADDR);
  wire ptr_hit = hit(IND_PTR_ADDR, 1'b0, I_ADDR);
  wire bank_hit = hit(BANK_SEL_ADDR, 1'b0, I_ADDR);
  wire ctl_wr = I_WR && ctl_hit;
  wire idle = (state == ST_IDLE);
  // starts need the enable already stored, both at once is refused
  wire read_start = ctl_wr && idle && I_WDATA[CTL_READ_GO]
                    && !I_WDATA[CTL_PROG_GO] && read_en;
  wire write_start = ctl_wr && idle && I_WDATA[CTL_PROG_GO]
                     && !I_WDATA[CTL_READ_GO] && prog_en;
  wire write_end = (state == ST_WRITE) && (wcount == 16'h0000);
  wire [3:0] ctl_val = {prog_en, prog_go, read_en, read_go};

  // read data selection, unimplemented bits zero
  wire [7:0] rd_sel =
    loc_hit ? {1'b0, nv_location} :
    byte_hit ? nv_byte :
    ctl_hit ? {4'h0, ctl_val} :
    ptr_hit ? ptr_one :
    bank_hit ? {7'h00, bank_sel} : 8'h00;

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  always_comb begin
    case (state)
      ST_IDLE: begin
        next_state = read_start ? ST_READ :
                     write_start ? ST_WRITE : ST_IDLE;
      end
      ST_READ: next_state = ST_IDLE;
      ST_WRITE: next_state = write_end ? ST_IDLE : ST_WRITE;
      default: next_state = ST_IDLE;
    endcase
  end

  assign mem_port.we = write_end;
  assign mem_port.addr = (state == ST_WRITE) ? wr_loc : nv_location;
  assign mem_port.wdata = wr_byte;

  // state and write timer
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      state <= ST_IDLE;
      wcount <= 16'h0000;
    end else begin
      state <= next_state;
      if (write_start) begin
        wcount <= 16'(WRITE_LEN - 1);
      end else if (state == ST_WRITE && !write_end) begin
        wcount <= wcount - 16'h0001;
      end
    end
  end

  // write operands frozen at start
  always_ff @(posedge I_CLK) begin
    if (write_start) begin
      wr_loc <= nv_location;
      wr_byte <= nv_byte;
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  // control bits; go bits only set by a start, cleared by hardware
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      {prog_en, prog_go, read_en, read_go} <= CTL_RESET;
    end else begin
      if (ctl_wr) begin
        prog_en <= I_WDATA[CTL_PROG_EN];
        read_en <= I_WDATA[CTL_READ_EN];
      end
      if (write_start) begin
        prog_go <= 1'b1;
      end else if (write_end) begin
        prog_go <= 1'b0;
      end
      if (read_start) begin
        read_go <= 1'b1;
      end else if (state == ST_READ) begin
        read_go <= 1'b0;
      end
    end
  end

  // bank select and pointer
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      bank_sel <= BANK_RESET;
      ptr_one <= 8'h00;
    end else begin
      if (I_WR && bank_hit) begin
        bank_sel <= I_WDATA[0];
      end
      if (I_WR && ptr_hit) begin
        ptr_one <= I_WDATA;
      end
    end
  end

  // location and byte registers
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      nv_location <= '0;
      nv_byte <= 8'h00;
    end else begin
      if (I_WR && loc_hit) begin
        nv_location <= I_WDATA[NV_AW-1:0];
      end
      if (state == ST_READ) begin
        nv_byte <= mem_port.rdata;
      end else if (I_WR && byte_hit) begin
        nv_byte <= I_WDATA;
      end
    end
  end

  // outputs; flag set wins over clear
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      O_RDATA <= 8'h00;
      O_DONE_FLAG <= 1'b0;
      O_MF_REQ <= 1'b0;
      O_BUSY <= 1'b0;
    end else begin
      O_RDATA <= rd_sel;
      O_DONE_FLAG <= write_end || (O_DONE_FLAG && !I_DONE_CLR);
      O_MF_REQ <= write_end || (O_MF_REQ && !I_MF_SERVICE);
      O_BUSY <= (next_state != ST_IDLE);
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);

  loc_top_zero_a: assert property (
    loc_hit |=> O_RDATA[7] == 1'b0) else $error("location bit 7 not zero");
  ctl_high_zero_a: assert property (
    ctl_hit |=> O_RDATA[7:4] == 4'h0) else $error("control top not zero");
  read_gated_a: assert property (
    (idle && ctl_wr && I_WDATA[CTL_READ_GO] && !read_en)
    |=> state != ST_READ) else $error("read began without enable");
  read_end_a: assert property (
    $rose(read_go) |=> !read_go && nv_byte == $past(mem_port.rdata))
    else $error("read go not cleared after one cycle");
  byte_hold_a: assert property (
    (state != ST_READ && !(I_WR && byte_hit)) |=> $stable(nv_byte))
    else $error("byte register changed");
  write_gated_a: assert property (
    (idle && ctl_wr && I_WDATA[CTL_PROG_GO] && !prog_en)
    |=> state != ST_WRITE) else $error("write began without enable");
  write_hold_a: assert property (
    (state == ST_WRITE && wcount != 16'h0000) |=> prog_go && !O_DONE_FLAG
    || $past(O_DONE_FLAG)) else $error("write go dropped early");
  done_flags_a: assert property (
    $fell(prog_go) |-> O_DONE_FLAG && O_MF_REQ && !O_BUSY)
    else $error("write end flags missing");
  busy_ignore_a: assert property (
    (state == ST_WRITE && !write_end) |=> !read_go && state == ST_WRITE
    || $past(wcount) == 16'h0000) else $error("start taken while busy");
  reset_clear_a: assert property (
    @(posedge I_CLK) disable iff (1'b0)
    !I_NRST |=> ctl_val == 4'h0 && bank_sel == 1'b0)
    else $error("reset left control or bank set");
endmodule : nv_access

//--- nv_access_pkg.sv
package nv_access_pkg;
  // --------------------------------------------------------------
  // register addresses and geometry
  // --------------------------------------------------------------
  localparam logic [7:0] IND_PORT_ADDR = 8'h02; // indirect_access_port
  localparam logic [7:0] IND_PTR_ADDR = 8'h03; // indirect_pointer_one
  localparam logic [7:0] BANK_SEL_ADDR = 8'h04; // bank_select
  localparam logic [7:0] NV_LOCATION_ADDR = 8'h41; // bank zero
  localparam logic [7:0] NV_BYTE_ADDR = 8'h42; // bank zero
  localparam logic [7:0] NV_CONTROL_ADDR = 8'h40; // bank one
  localparam int NV_DEPTH = 128;
  localparam int NV_AW = 7;
  // control field positions
  localparam int CTL_PROG_EN = 3;
  localparam int CTL_PROG_GO = 2;
  localparam int CTL_READ_EN = 1;
  localparam int CTL_READ_GO = 0;
  // reset values
  localparam logic [3:0] CTL_RESET = 4'h0;
  localparam logic BANK_RESET = 1'b0;
  // write cycle timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int WRITE_TIME_NS = 2000;
  localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } nv_state_t;
endpackage : nv_access_pkg

//--- nv_array.sv
`timescale 1ns/1ns
// --------------------------------------------------------------
// nonvolatile byte array, registered read
// --------------------------------------------------------------
module nv_array #(
  parameter int DEPTH = 128
) (
  input wire logic clk, // system clock
  nv_mem_if.mem port // sequencer side
);
  logic [7:0] cells [DEPTH];

  // one byte per access, read data always from a register
  always_ff @(posedge clk) begin
    if (port.we) begin
      cells[port.addr] <= port.wdata;
    end
    port.rdata <= cells[port.addr];
  end
endmodule : nv_array

//--- nv_mem_if.sv
`timescale 1ns/1ns
// --------------------------------------------------------------
// link between sequencer and array
// --------------------------------------------------------------
interface nv_mem_if #(parameter int AW = 7);
  logic we;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface : nv_mem_if

//--- tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  mismatches++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
  import nv_access_pkg::*;
  localparam int WLEN = 6;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, done_clr = 1'b0;
  logic mf_service = 1'b0, look = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, exp_v;
  logic done_flag, mf_req, busy;
  logic [7:0] q[$];
  logic [7:0] mem_exp[3];
  logic [6:0] locs[3];
  int mismatches = 0, check_count = 0, cycles = 0;
  // --------------------------------------------------------------
  // clock, design and watchdog
  // --------------------------------------------------------------
  always #10 clk = ~clk;
  nv_access #(.WRITE_LEN(WLEN)) nv_access_i (.I_CLK(clk), .I_NRST(nrst),
    .I_ADDR(addr), .I_WR(wr), .I_WDATA(wdata), .I_DONE_CLR(done_clr),
    .I_MF_SERVICE(mf_service), .O_RDATA(rdata), .O_DONE_FLAG(done_flag),
    .O_MF_REQ(mf_req), .O_BUSY(busy));
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // result watcher: pops the oldest note once read data has landed
  always @(posedge clk) begin
    if (look) begin
      #1;
      exp_v = q.pop_front();
      `CHK("O_RDATA", exp_v, rdata) // readback
    end
  end
  // --------------------------------------------------------------
  // bus tasks, entered just after a falling edge; report_and_stop also from the rising-edge watchdog
  // --------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    q.push_back(e);
    look = 1'b1;
    @(negedge clk);
    look = 1'b0;
    @(negedge clk);
  endtask : rd_reg
  // one-cycle pulse on the done clear or on the service input
  task automatic pulse(input bit to_done);
    if (to_done) begin
      done_clr = 1'b1;
    end else begin
      mf_service = 1'b1;
    end
    @(negedge clk);
    done_clr = 1'b0;
    mf_service = 1'b0;
    @(negedge clk);
  endtask : pulse
  // bounded wait for the sequencer to go idle
  task automatic wait_idle;
    for (int n = 0; n < 20 && busy !== 1'b0; n++) @(negedge clk);
    `CHK("O_BUSY", 1'b0, busy)
  endtask : wait_idle
  task automatic report_and_stop;
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    void'($urandom(380));
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    rd_reg(BANK_SEL_ADDR, 8'h00);
    rd_reg(NV_LOCATION_ADDR, 8'h00);
    rd_reg(8'h10, 8'h00); // unmapped place reads zero
    `CHK("O_DONE_FLAG", 1'b0, done_flag)
    wr_reg(IND_PTR_ADDR, 8'h40);
    wr_reg(BANK_SEL_ADDR, 8'h01);
    rd_reg(IND_PORT_ADDR, 8'h00);
    wr_reg(NV_LOCATION_ADDR, 8'hff);
    rd_reg(NV_LOCATION_ADDR, 8'h7f);
    wr_reg(NV_BYTE_ADDR, 8'ha5);
    rd_reg(NV_BYTE_ADDR, 8'ha5);
    // go bits without their enable start nothing
    wr_reg(IND_PORT_ADDR, 8'h04);
    `CHK("O_BUSY", 1'b0, busy)
    wr_reg(IND_PORT_ADDR, 8'h01);
    `CHK("O_BUSY", 1'b0, busy)
    wr_reg(IND_PORT_ADDR, 8'h0a);
    wr_reg(IND_PORT_ADDR, 8'h0f);
    `CHK("O_BUSY", 1'b0, busy)
    rd_reg(IND_PORT_ADDR, 8'h0a);
    // writes at both ends of the array and one random place
    locs = '{7'h00, 7'h7f, 7'($urandom_range(1, 126))};
    for (int i = 0; i < 3; i++) begin
      mem_exp[i] = 8'($urandom);
      wr_reg(IND_PORT_ADDR, 8'h08);
      wr_reg(NV_LOCATION_ADDR, {1'b0, locs[i]});
      wr_reg(NV_BYTE_ADDR, mem_exp[i]);
      wr_reg(IND_PORT_ADDR, 8'h0c);
      `CHK("O_BUSY", 1'b1, busy)
      wr_reg(NV_LOCATION_ADDR, 8'h33);
      `CHK("O_BUSY", 1'b1, busy)
      // a second go while busy must not restart the write timer
      wr_reg(IND_PORT_ADDR, 8'h0c);
      `CHK("O_BUSY", 1'b1, busy)
      @(negedge clk);
      `CHK("O_BUSY", 1'b0, busy)
      wait_idle();
      rd_reg(IND_PORT_ADDR, 8'h08);
      `CHK("O_DONE_FLAG", 1'b1, done_flag)
      `CHK("O_MF_REQ", 1'b1, mf_req)
      pulse(1'b0);
      `CHK("O_MF_REQ", 1'b0, mf_req)
      `CHK("O_DONE_FLAG", 1'b1, done_flag)
      pulse(1'b1);
      `CHK("O_DONE_FLAG", 1'b0, done_flag)
    end
    // read each back, location latched at write start
    for (int i = 0; i < 3; i++) begin
      wr_reg(IND_PORT_ADDR, 8'h02); // write enable dropped
      wr_reg(NV_LOCATION_ADDR, {1'b0, locs[i]});
      wr_reg(NV_BYTE_ADDR, ~mem_exp[i]);
      wr_reg(IND_PORT_ADDR, 8'h03);
      wait_idle();
      rd_reg(IND_PORT_ADDR, 8'h02);
      rd_reg(NV_BYTE_ADDR, mem_exp[i]);
      repeat (5) @(negedge clk);
      rd_reg(NV_BYTE_ADDR, mem_exp[i]);
      `CHK("O_DONE_FLAG", 1'b0, done_flag)
    end
    // reset again in mid-run with read enable and bank one set
    nrst = 1'b0;
    @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    rd_reg(BANK_SEL_ADDR, 8'h00);
    wr_reg(IND_PTR_ADDR, 8'h40);
    wr_reg(BANK_SEL_ADDR, 8'h01);
    rd_reg(IND_PORT_ADDR, 8'h00);
    wr_reg(IND_PORT_ADDR, 8'h00);
    rd_reg(IND_PORT_ADDR, 8'h00);
    @(negedge clk);
    report_and_stop();
  end
endmodule : tb_top
